//--- bench/bcr_config_regs_chk.sv
// checker: port timing of the configuration register bank
// assumes: bound into bcr_config_regs, one clock domain
`timescale 1ns/1ps
module bcr_config_regs_chk
   import bcr_pkg::*;
(
   input wire logic        clock, nrst, wrStrobe, rdStrobe, rdValid, rdError, alertAck,
   input wire logic        alertActive, chargingMode, chargeReduce, convStart,
   input wire logic [7:0]  cmdCode,
   input wire logic [15:0] wrData, rdData, capRefTenthMv,
   input wire logic [14:0] monStatus,
   input wire logic [3:0]  shuntOn, convChannel
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_rdv; rdStrobe |=> rdValid; endproperty
   a_rdv: assert property (p_rdv) else $error("read answer missing");
   property p_err; rdStrobe && cmdCode == 8'hFF |=> rdError && rdData == 16'h0000; endproperty
   a_err: assert property (p_err) else $error("unmapped read not flagged");
   property p_hold; !$past(rdStrobe) |-> $stable(rdData); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_alr; $rose(alertActive) |-> |($past(monStatus) & ~$past(monStatus, 2)); endproperty
   a_alr: assert property (p_alr) else $error("alert without rise");
   property p_ack; $fell(alertActive) |-> $past(alertAck); endproperty
   a_ack: assert property (p_ack) else $error("alert dropped early");
   property p_ref; wrStrobe && cmdCode == CMD_REG_REF |=> ##1 capRefTenthMv ==
      REF_BASE_TENTH_MV + REF_STEP_TENTH_MV * ($past(wrData, 2) & 16'h000F); endproperty
   a_ref: assert property (p_ref) else $error("reference wrong");
   property p_shn; |shuntOn |-> chargeReduce; endproperty
   a_shn: assert property (p_shn) else $error("shunt without reduce");
   property p_cnv; convStart |-> $past(chargingMode) && convChannel inside {[4'h1:4'hB]};
   endproperty
   a_cnv: assert property (p_cnv) else $error("bad conversion start");
endmodule
bind bcr_config_regs bcr_config_regs_chk chk_u (.*);

//--- bench/bcr_config_regs_test.sv
// testbench: register access, alerts, shunt limit and conversion round
// assumes: 10 MHz clock, host partner model, checker bound to the design
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module bcr_config_regs_test;
   import bcr_pkg::*;
   logic        clock = 0, nrst = 0, alertAck = 0, chargingMode = 0, wrStrobe, rdStrobe;
   logic        rdValid, rdError, alertActive, chargeReduce, convStart;
   logic [7:0]  cmdCode;
   logic [15:0] wrData, rdData, capRefTenthMv, q;
   logic [14:0] monStatus = '0;
   logic [63:0] cellVoltage = '0;
   logic [3:0]  shuntOn, convChannel;
   logic        e;
   int          mismatches = 0, checks = 0;
   bcr_config_regs #(.CONV_CYCLES(2)) dut_u (.*);
   bcr_host host_u (.*);
   initial forever #50 clock = ~clock;
   task wr(input logic [7:0] c, input logic [15:0] d);
      host_u.xfer(1'b1, c, d, q, e);
   endtask
   task rd(input logic [7:0] c, input logic [15:0] x);
      host_u.xfer(1'b0, c, 16'h0000, q, e);
      `CHK("rdValid", 1'b1, rdValid)
      `CHK("rdData", x, q)
      `CHK("rdError", c == 8'hFF, e)
   endtask
   task t_reset;
      rd(CMD_ALERT_MASK, 16'h0000);
      rd(CMD_REG_REF, 16'h000A);
      rd(CMD_SHUNT_V, 16'h3998);
      rd(CMD_CHG_CH_EN, 16'h0F02);
      rd(8'hFF, 16'h0000);
      `CHK("capRef", 16'h278D, capRefTenthMv)
   endtask
   task t_regs;
      wr(CMD_REG_REF, 16'hFFFF);
      wr(CMD_ALERT_MASK, 16'hFFFF);
      wr(CMD_CHG_CH_EN, 16'hFFFF);
      rd(CMD_REG_REF, 16'h000F);
      rd(CMD_ALERT_MASK, 16'h7FFF);
      rd(CMD_CHG_CH_EN, 16'h0FFE);
      `CHK("capRef", 16'h2EE0, capRefTenthMv)
   endtask
   task t_alert;
      for (int i = 11; i < 15; i++) begin
         wr(CMD_ALERT_MASK, 16'h0001 << i);
         @(posedge clock);
         monStatus <= 15'h0001 << i;
         repeat (3) @(posedge clock);
         `CHK("alert", 1'b1, alertActive)
         {alertAck, monStatus} <= {1'b1, 15'h0000};
         @(posedge clock);
         alertAck <= 1'b0;
         @(posedge clock);
         #1;
         `CHK("alertClr", 1'b0, alertActive)
      end
      @(posedge clock);
      monStatus <= 15'h2000;
      repeat (3) @(posedge clock);
      `CHK("unmasked", 1'b0, alertActive)
      monStatus <= 15'h0000;
   endtask
   task set_v(input logic [15:0] v, input logic [3:0] s, input logic r);
      @(posedge clock);
      cellVoltage <= {48'h0, v};
      repeat (2) @(posedge clock);
      #1;
      `CHK("shuntOn", s, shuntOn)
      `CHK("reduce", r, chargeReduce)
   endtask
   task t_shunt;
      set_v(16'h390F, 4'h1, 1'b1);
      set_v(16'h390E, 4'h0, 1'b0);
      wr(CMD_SHUNT_V, 16'h5000);
      set_v(16'h5000, 4'h0, 1'b1);
   endtask
   task t_conv;
      logic [3:0] ex [3];
      int         n;
      ex = '{4'h2, 4'h8, 4'h2};
      n = 0;
      wr(CMD_CHG_CH_EN, 16'h0104);
      @(posedge clock);
      chargingMode <= 1'b1;
      for (int k = 0; k < 40 && n < 3; k++) begin
         @(posedge clock);
         #1;
         if (convStart === 1'b1) begin
            `CHK("channel", ex[n], convChannel)
            n++;
         end
      end
      `CHK("starts", 3, n)
      @(posedge clock);
      chargingMode <= 1'b0;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      summarize;
   end
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_reset;
      t_regs;
      t_alert;
      t_shunt;
      t_conv;
      summarize;
   end
endmodule

//--- bench/bcr_host.sv
// partner: management bus host issuing command writes and reads
// assumes: strobes sampled at rising clock, read answer one cycle later
`timescale 1ns/1ps
module bcr_host (
   input  wire logic        clock,
   input  wire logic [15:0] rdData,
   input  wire logic        rdError,
   output logic             wrStrobe,
   output logic             rdStrobe,
   output logic      [7:0]  cmdCode,
   output logic      [15:0] wrData
);
   initial begin
      {wrStrobe, rdStrobe, cmdCode, wrData} = '0;
   end
   task xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
             output logic [15:0] q, output logic e);
      @(posedge clock);
      {wrStrobe, rdStrobe, cmdCode, wrData} <= {w, !w, c, d};
      @(posedge clock);
      // released bus shows no stale value
      {wrStrobe, rdStrobe, cmdCode, wrData} <= {2'b00, ~c, ~d};
      #1;
      q = rdData;
      e = rdError;
   endtask
endmodule

//--- common/bcr_pkg.sv
// package: command codes, reset values, field positions and scaling of the
// backup controller configuration registers
// assumes: one 10 MHz clock domain, synchronous active-low reset
package bcr_pkg;
   localparam logic [7:0]  CMD_ALERT_MASK   = 8'h02;
   localparam logic [7:0]  CMD_REG_REF      = 8'h03;
   localparam logic [7:0]  CMD_SHUNT_V      = 8'h05;
   localparam logic [7:0]  CMD_CHG_CH_EN    = 8'h06;
   localparam logic [15:0] RST_ALERT_MASK   = 16'h0000;
   localparam logic [3:0]  RST_REG_REF      = 4'hA;
   localparam logic [15:0] RST_SHUNT_V      = 16'h3998;
   localparam logic [11:0] RST_CHG_CH_EN    = 12'hF02;
   localparam logic [15:0] MASK_ALERT_BITS  = 16'h7FFF;
   localparam logic [11:0] MASK_CHG_CH_BITS = 12'hFFE;
   localparam int          BIT_PWR_RET      = 11;
   localparam int          BIT_BALANCING    = 12;
   localparam int          BIT_SHUNTING     = 13;
   localparam int          BIT_PRECHARGE    = 14;
   localparam int          CH_FIRST         = 1;
   localparam int          CH_LAST          = 11;
   // reference = base + step * code, in units of 0.1 mV
   localparam logic [15:0] REF_BASE_TENTH_MV = 16'h18E7;
   localparam logic [15:0] REF_STEP_TENTH_MV = 16'h0177;
   // shunt limit weight 182.8 uV per count; thresholds in counts
   localparam logic [15:0] SHUNT_3V6_COUNTS  = 16'h4CEE;
   localparam logic [15:0] SHUNT_25MV_COUNTS = 16'h0089;
   localparam int          NUM_CELLS         = 4;
endpackage

//--- hdl/bcr_config_regs.sv
// configuration register bank: alert mask, regulation reference, shunt
// limit, charging-mode channel enables, with the logic these registers steer
// assumes: command-addressed access decoded by the management bus engine;
// cell voltages arrive already digitised in shunt-limit counts
// Operation
// - mask bit 11 alerts on power-returned rise
// - mask bit 12 alerts on balancing rise
// - mask bit 13 alerts on shunting rise
// - mask bit 14 alerts on precharge rise
// - reference code bits 3:0, reset ten
// - reference is 637.5mV plus 37.5mV per code
// - below 3.6V shunt within 25mV of limit
// - above 3.6V never shunt, still reduce charge
// - reduce charge current nearing the limit
// - channel enables bits 11:1, reset 3842
// - bit 2 enables die temperature conversion
// - bits 3-7 enable gpi, iin, vout, vcap, vin
// - bits 9-11 enable cells two to four
// - mask writable; set bit enables rising alert
`timescale 1ns/1ps
module bcr_config_regs
   import bcr_pkg::*;
#(
   parameter int CONV_CYCLES = 16
) (
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic                 wrStrobe,
   input  wire logic                 rdStrobe,
   input  wire logic [7:0]           cmdCode,
   input  wire logic [15:0]          wrData,
   output logic      [15:0]          rdData,
   output logic                      rdValid,
   output logic                      rdError,
   input  wire logic [14:0]          monStatus,
   input  wire logic                 alertAck,
   output logic                      alertActive,
   input  wire logic                 chargingMode,
   input  wire logic [NUM_CELLS*16-1:0] cellVoltage,
   output logic      [15:0]          capRefTenthMv,
   output logic      [NUM_CELLS-1:0] shuntOn,
   output logic                      chargeReduce,
   output logic                      convStart,
   output logic      [3:0]           convChannel
);
   // slot counter is sixteen bits wide and must count at least one cycle
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_badConvCycles
      $error("CONV_CYCLES out of range");
   end

   logic [15:0] alertMask_q;
   logic [3:0]  regRef_q;
   logic [15:0] shuntV_q;
   logic [11:0] chgChEn_q;
   logic [14:0] monPrev_q;
   logic [15:0] convCnt_q;
   logic [3:0]  curCh_q;
   logic [14:0] monRise;
   logic        shuntAllowed;

   function automatic logic [3:0] next_enabled(input logic [3:0] from, input logic [11:0] en);
      logic [3:0] res;
      logic [3:0] c;
      res = from;
      c = from;
      for (int i = 0; i < CH_LAST; i++) begin
         c = (c >= 4'(CH_LAST)) ? 4'(CH_FIRST) : c + 4'h1;
         if (en[c] && res == from) begin
            res = c;
         end
      end
      return res;
   endfunction

   // register writes
   always_ff @(posedge clock) begin
      if (!nrst) begin
         alertMask_q <= RST_ALERT_MASK;
         regRef_q    <= RST_REG_REF;
         shuntV_q    <= RST_SHUNT_V;
         chgChEn_q   <= RST_CHG_CH_EN;
      end else if (wrStrobe) begin
         unique case (cmdCode)
            CMD_ALERT_MASK: alertMask_q <= wrData & MASK_ALERT_BITS;
            CMD_REG_REF:    regRef_q    <= wrData[3:0];
            CMD_SHUNT_V:    shuntV_q    <= wrData;
            CMD_CHG_CH_EN:  chgChEn_q   <= wrData[11:0] & MASK_CHG_CH_BITS;
            default: begin
            end
         endcase
      end
   end

   // register reads, unmapped codes flag an error and read zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdData  <= 16'h0000;
         rdValid <= 1'b0;
         rdError <= 1'b0;
      end else begin
         rdValid <= rdStrobe;
         rdError <= 1'b0;
         if (rdStrobe) begin
            unique case (cmdCode)
               CMD_ALERT_MASK: rdData <= alertMask_q;
               CMD_REG_REF:    rdData <= {12'h000, regRef_q};
               CMD_SHUNT_V:    rdData <= shuntV_q;
               CMD_CHG_CH_EN:  rdData <= {4'h0, chgChEn_q};
               default: begin
                  rdData  <= 16'h0000;
                  rdError <= 1'b1;
               end
            endcase
         end
      end
   end

   // alert on masked rising edges of monitor status, held until acknowledged
   assign monRise = monStatus & ~monPrev_q;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         monPrev_q   <= 15'h0000;
         alertActive <= 1'b0;
      end else begin
         monPrev_q <= monStatus;
         if (|(monRise & alertMask_q[14:0])) begin
            alertActive <= 1'b1;
         end else if (alertAck) begin
            alertActive <= 1'b0;
         end
      end
   end

   // feedback reference from the code
   always_ff @(posedge clock) begin
      if (!nrst) begin
         capRefTenthMv <= REF_BASE_TENTH_MV;
      end else begin
         capRefTenthMv <= REF_BASE_TENTH_MV + 16'(REF_STEP_TENTH_MV * regRef_q);
      end
   end

   // shunt and charge-reduction comparisons per cell
   assign shuntAllowed = shuntV_q < SHUNT_3V6_COUNTS;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         shuntOn      <= '0;
         chargeReduce <= 1'b0;
      end else begin
         logic anyNear;
         anyNear = 1'b0;
         for (int k = 0; k < NUM_CELLS; k++) begin
            logic near;
            near = ({1'b0, cellVoltage[k*16 +: 16]} + {1'b0, SHUNT_25MV_COUNTS})
                   >= {1'b0, shuntV_q};
            shuntOn[k] <= near && shuntAllowed;
            anyNear = anyNear | near;
         end
         chargeReduce <= anyNear;
      end
   end

   // charging-mode measurement round over enabled channels only
   always_ff @(posedge clock) begin
      if (!nrst) begin
         convCnt_q   <= 16'h0000;
         curCh_q     <= 4'(CH_LAST);
         convStart   <= 1'b0;
         convChannel <= 4'h0;
      end else begin
         convStart <= 1'b0;
         if (!chargingMode || chgChEn_q == 12'h000) begin
            convCnt_q <= 16'h0000;
         end else if (convCnt_q == 16'h0000) begin
            logic [3:0] nxt;
            nxt = next_enabled(curCh_q, chgChEn_q);
            if (chgChEn_q[nxt]) begin
               curCh_q     <= nxt;
               convChannel <= nxt;
               convStart   <= 1'b1;
               convCnt_q   <= 16'(CONV_CYCLES - 1);
            end
         end else begin
            convCnt_q <= convCnt_q - 16'h0001;
         end
      end
   end
endmodule
